// ==== hw/rrm_core.sv ====
// Time, calendar, alarm, trim and control registers of the clock behind its register port
//
// What this block does
// - Every implemented bit of the fifteen registers reads and writes, except control register two flags, which writes only clear.
// - Unimplemented bits ignore writes and read zero.
// - While power-on flag set, trim and both control registers clear, except halt bit and the power-on flag itself.
// - Trim accuracy select picks coarse or fine correction granularity.
// - Control register one reads all zero after power-on from zero volts.
// - Weekly and daily alarm enables gate their alarm logic.
// - Control register one bit 5 selects 12-hour or 24-hour counting.
// - 12-hour code: 12 midnight, 01-11 morning, bit 5 marks afternoon.
// - Spare bit two stores and returns the host value only.
// - Spare bit two clears when the power-on flag is set.
// - Year divisible by four, including 00, is a leap year.
// - Weekly alarm matches minute, hour, weekday set; daily matches hour, minute.
// - Power-on flag accepts written zero only.
`include "rrm_consts.svh"
`default_nettype none
module rrm_core #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire rrm_pkg::rrm_req_type reg_req,
   input wire rrm_pkg::rrm_event_type events,
   output logic [7:0] reg_rdata,
   output logic weekly_alarm_hit,
   output logic daily_alarm_hit,
   output logic trim_apply,
   output logic [6:0] trim_code
);
   if (DATA_W != 8 || ADDR_W != 4) begin : g_width_check
      $error("rrm_core serves only 8-bit data and 4-bit addresses");
   end

   logic [7:0] seconds_count, minutes_count, hours_count, weekday_count;
   logic [7:0] monthday_count, month_century, year_count, rate_trim;
   logic [7:0] weekly_alarm_minute, weekly_alarm_hour, weekly_alarm_days;
   logic [7:0] daily_alarm_minute, daily_alarm_hour, control_primary;
   logic supply_level_select, supply_low_flag, osc_halt_indicator;
   logic power_on_flag, spare_bit_one;
   logic periodic_flag, weekly_alarm_flag, daily_alarm_flag;
   logic [5:0] trim_sec;

   function automatic logic [7:0] bcd_next(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_next = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_next = v + 8'h01;
      end
   endfunction

   // 12-hour sequence 12,01..11 then flip afternoon bit at 11 -> 12
   function automatic logic [7:0] hour_next(input logic [7:0] h, input logic h24);
      if (h24) begin
         hour_next = (h == 8'h23) ? 8'h00 : bcd_next(h);
      end else if (h[4:0] == 5'h12) begin
         hour_next = {2'b00, h[5], 5'h01};
      end else if (h[4:0] == 5'h11) begin
         hour_next = {2'b00, ~h[5], 5'h12};
      end else begin
         hour_next = {2'b00, h[5], 5'(bcd_next({3'b000, h[4:0]}))};
      end
   endfunction

   // Two-digit BCD year: tens even needs ones 0,4,8; tens odd needs 2,6
   function automatic logic [7:0] month_last(input logic [4:0] m, input logic [7:0] y);
      logic leap;
      leap = (y[1:0] == {y[4], 1'b0});
      unique case (m)
         5'h02: month_last = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
         default: month_last = 8'h31;
      endcase
   endfunction

   logic wr, power_on_hold;
   logic [3:0] wa;
   logic [7:0] wd;
   assign wr = reg_req.wr;
   assign wa = reg_req.addr;
   assign wd = reg_req.wdata;
   assign power_on_hold = power_on_flag | events.power_on;

   // Carry chain of the time base
   logic c_min, c_hour, c_day, c_month, c_year;
   logic [7:0] next_minutes, next_hours, next_weekday;
   assign c_min = events.tick_1hz && seconds_count == 8'h59;
   assign c_hour = c_min && minutes_count == 8'h59;
   assign c_day = c_hour && (control_primary[`RRM_BIT_H24] ?
                  hours_count == 8'h23 : hours_count == 8'h31);
   assign c_month = c_day &&
                    monthday_count == month_last(month_century[4:0], year_count);
   assign c_year = c_month && month_century[4:0] == 5'h12;
   assign next_minutes = c_hour ? 8'h00 : bcd_next(minutes_count);
   assign next_hours = c_hour ? hour_next(hours_count, control_primary[`RRM_BIT_H24])
                       : hours_count;
   assign next_weekday = c_day ? ((weekday_count == 8'h06) ? 8'h00 : weekday_count + 8'h01)
                         : weekday_count;

   // Time counters; a host write to a counter wins over its increment
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seconds_count <= `RRM_RST_ZERO;
         minutes_count <= `RRM_RST_ZERO;
         hours_count <= `RRM_RST_ZERO;
         weekday_count <= `RRM_RST_ZERO;
         monthday_count <= `RRM_RST_ONE;
         month_century <= `RRM_RST_ONE;
         year_count <= `RRM_RST_ZERO;
      end else begin
         if (wr && wa == `RRM_ADDR_SEC) begin
            seconds_count <= wd & `RRM_MASK_MINSEC;
         end else if (events.tick_1hz) begin
            seconds_count <= c_min ? 8'h00 : bcd_next(seconds_count);
         end
         if (wr && wa == `RRM_ADDR_MIN) begin
            minutes_count <= wd & `RRM_MASK_MINSEC;
         end else if (c_min) begin
            minutes_count <= next_minutes;
         end
         if (wr && wa == `RRM_ADDR_HOUR) begin
            // Stored as written; the host picks the format first
            hours_count <= wd & `RRM_MASK_HOUR;
         end else begin
            hours_count <= next_hours;
         end
         if (wr && wa == `RRM_ADDR_WDAY) begin
            weekday_count <= wd & `RRM_MASK_WDAY;
         end else begin
            weekday_count <= next_weekday;
         end
         if (wr && wa == `RRM_ADDR_MDAY) begin
            monthday_count <= wd & `RRM_MASK_MDAY;
         end else if (c_day) begin
            monthday_count <= c_month ? 8'h01 : bcd_next(monthday_count);
         end
         if (wr && wa == `RRM_ADDR_MONTH) begin
            month_century <= wd & `RRM_MASK_MONTH;
         end else if (c_month) begin
            month_century[4:0] <= c_year ? 5'h01 : 5'(bcd_next({3'b000, month_century[4:0]}));
            if (c_year && year_count == 8'h99) begin
               month_century[`RRM_BIT_CENTURY] <= ~month_century[`RRM_BIT_CENTURY];
            end
         end
         if (wr && wa == `RRM_ADDR_YEAR) begin
            year_count <= wd;
         end else if (c_year) begin
            year_count <= (year_count == 8'h99) ? 8'h00 : bcd_next(year_count);
         end
      end
   end

   // Alarm settings
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         weekly_alarm_minute <= `RRM_RST_ZERO;
         weekly_alarm_hour <= `RRM_RST_ZERO;
         weekly_alarm_days <= `RRM_RST_ZERO;
         daily_alarm_minute <= `RRM_RST_ZERO;
         daily_alarm_hour <= `RRM_RST_ZERO;
      end else if (wr) begin
         unique case (wa)
            `RRM_ADDR_WA_MIN: weekly_alarm_minute <= wd & `RRM_MASK_MINSEC;
            `RRM_ADDR_WA_HOUR: weekly_alarm_hour <= wd & `RRM_MASK_HOUR;
            `RRM_ADDR_WA_DAYS: weekly_alarm_days <= wd & `RRM_MASK_WDAYS;
            `RRM_ADDR_DA_MIN: daily_alarm_minute <= wd & `RRM_MASK_MINSEC;
            `RRM_ADDR_DA_HOUR: daily_alarm_hour <= wd & `RRM_MASK_HOUR;
            default: ;
         endcase
      end
   end

   // Alarms fire on the minute boundary into the matching time
   logic weekly_match, daily_match;
   assign weekly_match = control_primary[`RRM_BIT_WEEKLY_EN] && c_min &&
                         next_minutes == weekly_alarm_minute &&
                         next_hours == weekly_alarm_hour &&
                         weekly_alarm_days[next_weekday[2:0]];
   assign daily_match = control_primary[`RRM_BIT_DAILY_EN] && c_min &&
                        next_minutes == daily_alarm_minute &&
                        next_hours == daily_alarm_hour;

   // Trim and control register one; held clear while the power-on flag stands
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rate_trim <= `RRM_RST_ZERO;
         control_primary <= `RRM_RST_ZERO;
      end else if (power_on_hold) begin
         rate_trim <= `RRM_RST_ZERO;
         control_primary <= `RRM_RST_ZERO;
      end else if (wr) begin
         if (wa == `RRM_ADDR_TRIM) begin
            rate_trim <= wd;
         end
         if (wa == `RRM_ADDR_CTRL1) begin
            control_primary <= wd;
         end
      end
   end

   // Control register two; hardware sets win over host clears
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supply_level_select <= 1'b0;
         supply_low_flag <= 1'b0;
         osc_halt_indicator <= 1'b0;
         power_on_flag <= 1'b1;
         spare_bit_one <= 1'b0;
         periodic_flag <= 1'b0;
         weekly_alarm_flag <= 1'b0;
         daily_alarm_flag <= 1'b0;
      end else begin
         if (events.power_on) begin
            power_on_flag <= 1'b1;
         end else if (wr && wa == `RRM_ADDR_CTRL2 && !wd[`RRM_BIT_POWER_ON]) begin
            power_on_flag <= 1'b0;
         end
         if (events.osc_halt) begin
            osc_halt_indicator <= 1'b0;
         end else if (wr && wa == `RRM_ADDR_CTRL2) begin
            osc_halt_indicator <= wd[5];
         end
         if (power_on_hold) begin
            {supply_level_select, supply_low_flag, spare_bit_one} <= 3'h0;
            {periodic_flag, weekly_alarm_flag, daily_alarm_flag} <= 3'h0;
         end else begin
            if (wr && wa == `RRM_ADDR_CTRL2) begin
               supply_level_select <= wd[7];
               spare_bit_one <= wd[3];
            end
            if (events.supply_low) begin
               supply_low_flag <= 1'b1;
            end else if (wr && wa == `RRM_ADDR_CTRL2 && !wd[`RRM_BIT_SUPPLY_LOW]) begin
               supply_low_flag <= 1'b0;
            end
            if (wr && wa == `RRM_ADDR_CTRL2 && !wd[`RRM_BIT_PERIODIC_FLAG]) begin
               periodic_flag <= 1'b0;
            end
            if (weekly_match) begin
               weekly_alarm_flag <= 1'b1;
            end else if (wr && wa == `RRM_ADDR_CTRL2 && !wd[`RRM_BIT_WEEKLY_FLAG]) begin
               weekly_alarm_flag <= 1'b0;
            end
            if (daily_match) begin
               daily_alarm_flag <= 1'b1;
            end else if (wr && wa == `RRM_ADDR_CTRL2 && !wd[`RRM_BIT_DAILY_FLAG]) begin
               daily_alarm_flag <= 1'b0;
            end
         end
      end
   end

   // Correction applied every 20 s coarse, or every 60 s fine (3 ppm vs 1 ppm steps)
   logic [5:0] trim_period;
   assign trim_period = rate_trim[`RRM_BIT_TRIM_FINE] ? `RRM_TRIM_FINE_SEC
                        : `RRM_TRIM_COARSE_SEC;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_sec <= 6'h00;
         trim_apply <= 1'b0;
         trim_code <= 7'h00;
      end else begin
         trim_apply <= 1'b0;
         if (events.tick_1hz) begin
            if (trim_sec >= trim_period - 6'h01) begin
               trim_sec <= 6'h00;
               trim_apply <= rate_trim[6:0] != 7'h00;
               trim_code <= rate_trim[6:0];
            end else begin
               trim_sec <= trim_sec + 6'h01;
            end
         end
      end
   end

   // Alarm outputs follow the flags only while enabled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         weekly_alarm_hit <= 1'b0;
         daily_alarm_hit <= 1'b0;
      end else begin
         weekly_alarm_hit <= weekly_alarm_flag & control_primary[`RRM_BIT_WEEKLY_EN];
         daily_alarm_hit <= daily_alarm_flag & control_primary[`RRM_BIT_DAILY_EN];
      end
   end

   // Read data one cycle after the read strobe; the slot at D reads zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         unique case (wa)
            `RRM_ADDR_SEC: reg_rdata <= seconds_count;
            `RRM_ADDR_MIN: reg_rdata <= minutes_count;
            `RRM_ADDR_HOUR: reg_rdata <= hours_count;
            `RRM_ADDR_WDAY: reg_rdata <= weekday_count;
            `RRM_ADDR_MDAY: reg_rdata <= monthday_count;
            `RRM_ADDR_MONTH: reg_rdata <= month_century;
            `RRM_ADDR_YEAR: reg_rdata <= year_count;
            `RRM_ADDR_TRIM: reg_rdata <= rate_trim;
            `RRM_ADDR_WA_MIN: reg_rdata <= weekly_alarm_minute;
            `RRM_ADDR_WA_HOUR: reg_rdata <= weekly_alarm_hour;
            `RRM_ADDR_WA_DAYS: reg_rdata <= weekly_alarm_days;
            `RRM_ADDR_DA_MIN: reg_rdata <= daily_alarm_minute;
            `RRM_ADDR_DA_HOUR: reg_rdata <= daily_alarm_hour;
            `RRM_ADDR_CTRL1: reg_rdata <= control_primary;
            `RRM_ADDR_CTRL2: reg_rdata <= {supply_level_select, supply_low_flag,
                                           osc_halt_indicator, power_on_flag, spare_bit_one,
                                           periodic_flag, weekly_alarm_flag, daily_alarm_flag};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule // rrm_core
`default_nettype wire

// ==== shared/rrm_consts.svh ====
// Register offsets, field positions, masks and timing counts of the clock register map
`ifndef RRM_CONSTS_SVH
`define RRM_CONSTS_SVH
`define RRM_ADDR_SEC 4'h0
`define RRM_ADDR_MIN 4'h1
`define RRM_ADDR_HOUR 4'h2
`define RRM_ADDR_WDAY 4'h3
`define RRM_ADDR_MDAY 4'h4
`define RRM_ADDR_MONTH 4'h5
`define RRM_ADDR_YEAR 4'h6
`define RRM_ADDR_TRIM 4'h7
`define RRM_ADDR_WA_MIN 4'h8
`define RRM_ADDR_WA_HOUR 4'h9
`define RRM_ADDR_WA_DAYS 4'hA
`define RRM_ADDR_DA_MIN 4'hB
`define RRM_ADDR_DA_HOUR 4'hC
`define RRM_ADDR_CTRL1 4'hE
`define RRM_ADDR_CTRL2 4'hF
`define RRM_MASK_MINSEC 8'h7F
`define RRM_MASK_HOUR 8'h3F
`define RRM_MASK_WDAY 8'h07
`define RRM_MASK_MDAY 8'h3F
`define RRM_MASK_MONTH 8'h9F
`define RRM_MASK_WDAYS 8'h7F
`define RRM_BIT_WEEKLY_EN 7
`define RRM_BIT_DAILY_EN 6
`define RRM_BIT_H24 5
`define RRM_BIT_PM 5
`define RRM_BIT_CENTURY 7
`define RRM_BIT_TRIM_FINE 7
`define RRM_BIT_SUPPLY_LOW 6
`define RRM_BIT_POWER_ON 4
`define RRM_BIT_PERIODIC_FLAG 2
`define RRM_BIT_WEEKLY_FLAG 1
`define RRM_BIT_DAILY_FLAG 0
`define RRM_RST_ZERO 8'h00
`define RRM_RST_ONE 8'h01
`define RRM_TRIM_COARSE_SEC 6'h14
`define RRM_TRIM_FINE_SEC 6'h3C
`endif

// ==== shared/rrm_pkg.sv ====
// Types shared by the clock register map and its users
`default_nettype none
package rrm_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } rrm_req_type;
   typedef struct packed {
      logic tick_1hz;
      logic power_on;
      logic osc_halt;
      logic supply_low;
   } rrm_event_type;
endpackage
`default_nettype wire

// ==== test/rrm_core_bench.sv ====
// Self-checking bench for the clock register map
`default_nettype none
module rrm_core_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   rrm_pkg::rrm_req_type reg_req;
   rrm_pkg::rrm_event_type ev = '0;
   logic [7:0] reg_rdata;
   logic weekly_alarm_hit;
   logic daily_alarm_hit;
   logic trim_apply;
   logic [6:0] trim_code;
   logic [6:0] seen_code = 7'h00;
   logic [7:0] q;
   logic [7:0] d;
   logic [3:0] a;
   logic [7:0] tv [7];
   logic [7:0] hrs [6] = '{8'h11, 8'h31, 8'h12, 8'h32, 8'h23, 8'h11};
   logic [7:0] hexp [6] = '{8'h32, 8'h12, 8'h01, 8'h21, 8'h00, 8'h12};
   // Columns: year, month, day written; day, month, year expected
   logic [7:0] cal [4][6] = '{'{8'h00, 8'h02, 8'h28, 8'h29, 8'h02, 8'h00},
      '{8'h04, 8'h02, 8'h29, 8'h01, 8'h03, 8'h04}, '{8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01},
      '{8'h99, 8'h12, 8'h31, 8'h01, 8'h81, 8'h00}};
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   int trims = 0;
   always #5 clk = ~clk;
   rrm_core DUT (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .events(ev), .reg_rdata(reg_rdata),
      .weekly_alarm_hit(weekly_alarm_hit), .daily_alarm_hit(daily_alarm_hit),
      .trim_apply(trim_apply), .trim_code(trim_code));
   rrm_host HOST (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (trim_apply) begin
         trims++;
         seen_code = trim_code;
      end
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [7:0] msk(input logic [3:0] r);
      case (r)
         4'h2, 4'h4, 4'h9, 4'hC: return 8'h3F;
         4'h3: return 8'h07;
         4'h5: return 8'h9F;
         4'h6, 4'h7, 4'hE: return 8'hFF;
         4'hD: return 8'h00;
         default: return 8'h7F;
      endcase
   endfunction
   task automatic rw(input logic w, input logic [3:0] r, input logic [7:0] v,
      input logic [7:0] e, input string what);
      logic [7:0] got;
      HOST.acc(w, r, v, got);
      chk(what, e, got);
   endtask
   // k selects tick_1hz (0), power_on (1), osc_halt (2) or supply_low (3)
   task automatic pulse(input int k);
      #1 ev = 4'b1000 >> k;
      @(posedge clk);
      #1 ev = '0;
      @(posedge clk);
   endtask
   // Hour format first, then the seven time bytes from tv, then one second tick
   task automatic step(input logic [7:0] c);
      logic [7:0] r;
      HOST.acc(1'b1, 4'hE, c, r);
      for (int i = 0; i < 7; i++) begin
         HOST.acc(1'b1, 4'(i), tv[i], r);
      end
      pulse(0);
   endtask
   initial begin
      int prev;
      int h0;
      void'($urandom(32'hDCBE));
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      @(posedge clk);
      rw(1'b0, 4'hE, 8'h00, 8'h00, "ctrl1 reset");
      rw(1'b0, 4'hF, 8'h00, 8'h10, "ctrl2 reset");
      rw(1'b1, 4'hE, 8'hFF, 8'h00, "ctrl1 locked");
      rw(1'b1, 4'h7, 8'hFF, 8'h00, "trim locked");
      rw(1'b1, 4'hF, 8'hFF, 8'h30, "ctrl2 locked");
      rw(1'b1, 4'hF, 8'h00, 8'h00, "flag cleared");
      rw(1'b1, 4'hF, 8'h1F, 8'h08, "flag kept clear");
      rw(1'b1, 4'hF, 8'h68, 8'h28, "halt bit kept");
      pulse(2);
      pulse(3);
      rw(1'b0, 4'hF, 8'h00, 8'h48, "status events");
      rw(1'b1, 4'hD, 8'hFF, 8'h00, "unused slot");
      for (int i = 0; i < 30; i++) begin
         a = 4'($urandom_range(0, 14));
         d = 8'($urandom()) & ((a == 4'hE) ? 8'hF7 : 8'hFF);
         rw(1'b1, a, d, d & msk(a), "round trip");
      end
      rw(1'b1, 4'hE, 8'h10, 8'h10, "spare bit");
      pulse(1);
      repeat (2) @(posedge clk);
      rw(1'b0, 4'hF, 8'h00, 8'h10, "flag set");
      rw(1'b0, 4'hE, 8'h00, 8'h00, "spare cleared");
      rw(1'b0, 4'h7, 8'h00, 8'h00, "trim cleared");
      rw(1'b1, 4'hF, 8'h00, 8'h00, "flag cleared");
      for (int i = 0; i < 6; i++) begin
         tv = '{8'h59, 8'h59, hrs[i], 8'h03, 8'h10, 8'h05, 8'h07};
         step((i < 4) ? 8'h00 : 8'h20);
         rw(1'b0, 4'h2, 8'h00, hexp[i], "hour roll");
      end
      for (int i = 0; i < 4; i++) begin
         tv = '{8'h59, 8'h59, 8'h23, 8'h03, cal[i][2], cal[i][1], cal[i][0]};
         step(8'h20);
         rw(1'b0, 4'h4, 8'h00, cal[i][3], "month day");
         rw(1'b0, 4'h5, 8'h00, cal[i][4], "month");
         rw(1'b0, 4'h6, 8'h00, cal[i][5], "year");
      end
      rw(1'b1, 4'h8, 8'h30, 8'h30, "weekly minute");
      rw(1'b1, 4'h9, 8'h08, 8'h08, "weekly hour");
      rw(1'b1, 4'hB, 8'h30, 8'h30, "daily minute");
      rw(1'b1, 4'hC, 8'h08, 8'h08, "daily hour");
      for (int k = 0; k < 8; k++) begin
         HOST.acc(1'b1, 4'hF, 8'h00, q);
         HOST.acc(1'b1, 4'hA, k[2] ? 8'h77 : 8'h08, q);
         tv = '{8'h59, 8'h29, 8'h08, 8'h03, 8'h15, 8'h06, 8'h24};
         step({k[1:0], 6'h20});
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk("weekly hit", {7'h00, k[1] & !k[2]}, {7'h00, weekly_alarm_hit});
         chk("daily hit", {7'h00, k[0]}, {7'h00, daily_alarm_hit});
         @(posedge clk);
      end
      for (int j = 0; j < 2; j++) begin
         HOST.acc(1'b1, 4'h7, (j == 1) ? 8'h85 : 8'h05, q);
         prev = -1;
         h0 = trims;
         for (int n = 0; n < ((j == 1) ? 180 : 60); n++) begin
            pulse(0);
            @(negedge clk);
            if (trims != h0) begin
               if (prev >= 0) chk("trim gap", (j == 1) ? 8'h3C : 8'h14, 8'(n - prev));
               prev = n;
               h0 = trims;
            end
            @(posedge clk);
         end
         chk("trim code", 8'h05, {1'b0, seen_code});
      end
      give_verdict();
   end
endmodule // rrm_core_bench
`default_nettype wire

// ==== test/rrm_core_properties.sv ====
// Port-level concurrent checks for the clock register map
`default_nettype none
module rrm_props (
   input wire logic clk,
   input wire logic rst_b,
   input wire rrm_pkg::rrm_req_type reg_req,
   input wire rrm_pkg::rrm_event_type events,
   input wire logic [7:0] reg_rdata,
   input wire logic weekly_alarm_hit,
   input wire logic daily_alarm_hit,
   input wire logic trim_apply,
   input wire logic [6:0] trim_code
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // No write may intervene, else the host could have cleared the flag
   sequence s_power_on_quiet;
      events.power_on ##1 (!reg_req.wr)[*3];
   endsequence
   sequence s_year_wr_rd;
      reg_req.wr && !reg_req.rd && reg_req.addr == 4'h6
      ##1 reg_req.rd && !reg_req.wr && reg_req.addr == 4'h6;
   endsequence
   a_power_on_clears: assert property (s_power_on_quiet ##1
      (reg_req.rd && reg_req.addr inside {4'h7, 4'hE, 4'hF}) |=>
      (reg_rdata & 8'hDF) == (($past(reg_req.addr) == 4'hF) ? 8'h10 : 8'h00))
      else $error("control byte not cleared while power-on flag set");
   a_slot_d_zero: assert property (reg_req.rd && reg_req.addr == 4'hD |=>
      reg_rdata == 8'h00) else $error("unused slot read nonzero");
   a_top_bit_zero: assert property (reg_req.rd &&
      reg_req.addr inside {4'h0, 4'h1, 4'h8, 4'hA, 4'hB} |=> !reg_rdata[7])
      else $error("unimplemented bit 7 read as one");
   a_hour_top_zero: assert property (reg_req.rd &&
      reg_req.addr inside {4'h2, 4'h4, 4'h9, 4'hC} |=> reg_rdata[7:6] == 2'b00)
      else $error("unimplemented bits 7 and 6 read as one");
   a_year_write_read: assert property (s_year_wr_rd |=>
      reg_rdata == $past(reg_req.wdata, 2)) else $error("year byte not read back");
   a_weekly_after_tick: assert property ($rose(weekly_alarm_hit) |->
      $past(events.tick_1hz, 2) || $past(events.tick_1hz, 3))
      else $error("weekly hit rose without a second tick");
   a_daily_after_tick: assert property ($rose(daily_alarm_hit) |->
      $past(events.tick_1hz, 2) || $past(events.tick_1hz, 3))
      else $error("daily hit rose without a second tick");
   a_trim_code_latch: assert property ($changed(trim_code) |-> trim_apply)
      else $error("trim code changed outside a trim pulse");
   a_trim_spacing: assert property (trim_apply |=> (!trim_apply)[*8])
      else $error("trim pulses too close together");
endmodule // rrm_props
bind rrm_core rrm_props u_props (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .events(events),
   .reg_rdata(reg_rdata), .weekly_alarm_hit(weekly_alarm_hit), .daily_alarm_hit(daily_alarm_hit),
   .trim_apply(trim_apply), .trim_code(trim_code));
`default_nettype wire

// ==== test/rrm_host.sv ====
// Host model driving the parallel register port
`default_nettype none
module rrm_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output var rrm_pkg::rrm_req_type reg_req
);
   timeunit 1ns;
   timeprecision 100ps;
   initial reg_req = '0;
   // Optional write, then a read of the same byte on the very next edge
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q);
      if (w) begin
         #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
         @(posedge clk);
      end
      #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      #1 reg_req = '0;
      @(negedge clk) q = reg_rdata;
      @(posedge clk);
   endtask
endmodule // rrm_host
`default_nettype wire
